// File: hw/scg_standby.sv
// Standby controller: stop and wait modes, clock gating and bus fixation
`timescale 1ns/10ps
`default_nettype none

module scg_standby
   import scg_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [SCG_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic stop_mode,
   input wire logic wait_mode,
   input wire scg_irq_s irq_req,
   input wire logic [2:0] processor_priority_level,
   input wire logic byte_bus,
   input wire scg_pins_s bus_pins,
   input wire scg_pins_s port_pins,
   output scg_pins_s pin_out,
   output scg_gate_s clk_gate,
   output scg_periph_s periph_ctl,
   output logic [3:0] oscillator_divide_clocks,
   output logic irq_wake
);

   // ****************************
   // Register file
   // ****************************
   logic [SCG_CTRL_W-1:0] ctrl_q;
   logic [SCG_CTRL_W-1:0] ctrl_d;
   logic [1:0] done_q;
   logic [1:0] done_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   scg_state_e state_q;
   scg_state_e state_d;
   logic [SCG_WDT_W-1:0] wdt_q;
   logic [SCG_WDT_W-1:0] wdt_d;
   logic [SCG_PRE_W-1:0] pre_q;
   logic [SCG_PRE_W-1:0] pre_d;
   logic sel_clk_q;
   logic sel_clk_d;
   scg_gate_s gate_q;
   scg_gate_s gate_d;
   scg_periph_s periph_q;
   scg_periph_s periph_d;
   scg_pins_s pins_q;
   scg_pins_s pins_d;
   logic [SCG_PIN_W-1:0] port_sel;
   logic stop_go;
   logic wait_go;
   logic wake;
   logic sel_clk;
   logic sel_fall;
   logic fast_exit;
   logic ext_clk;
   logic pll_en;

   assign ext_clk = ctrl_q[SCG_CTRL_EXT_CLK];
   assign pll_en = ctrl_q[SCG_CTRL_PLL_EN];
   assign stop_go = stop_mode && !ctrl_q[SCG_CTRL_STOP_DIS];
   assign wait_go = wait_mode;
   assign wake = irq_req.pending && irq_req.enabled && (irq_req.level > processor_priority_level);
   assign fast_exit = ext_clk && !ctrl_q[SCG_CTRL_SYS_PLL];

   always_comb
   begin
      ctrl_d = ctrl_q;
      done_d = done_q;
      rdata_d = 32'h0000_0000;
      if (reg_wr && reg_addr == SCG_OFF_CTRL)
      begin
         ctrl_d = reg_wdata[SCG_CTRL_W-1:0];
         // PLL select cannot be set while the PLL is off
         if (!reg_wdata[SCG_CTRL_PLL_EN])
         begin
            ctrl_d[SCG_CTRL_SYS_PLL] = 1'b0;
         end
      end
      if (reg_wr && reg_addr == SCG_OFF_STAT)
      begin
         done_d = done_q & reg_wdata[1:0];
      end
      if (state_q == SCG_RUN && stop_go)
      begin
         done_d[SCG_STAT_STOP_DONE] = 1'b1;
      end
      else if (state_q == SCG_RUN && wait_go)
      begin
         done_d[SCG_STAT_WAIT_DONE] = 1'b1;
      end
      if (reg_rd)
      begin
         case (reg_addr)
            SCG_OFF_CTRL:
            begin
               rdata_d[SCG_CTRL_W-1:0] = ctrl_q;
            end
            SCG_OFF_STAT:
            begin
               rdata_d[1:0] = done_q;
               rdata_d[SCG_STAT_STATE +: 2] = state_q;
               rdata_d[SCG_STAT_WDT +: SCG_WDT_W] = wdt_q;
            end
            default:
            begin
               rdata_d = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q <= SCG_CTRL_RESET;
         done_q <= 2'h0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         done_q <= done_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ****************************
   // Oscillator divide clocks
   // ****************************
   always_comb
   begin
      pre_d = pre_q + 7'h01;
      if (state_q == SCG_STOP || state_d == SCG_STOP)
      begin
         pre_d = SCG_PRE_IDLE;
      end
   end

   assign sel_clk = pre_q[SCG_PRE_TAP0 + 32'(ctrl_q[SCG_CTRL_WDT_SEL +: 2])];
   assign sel_clk_d = sel_clk;
   assign sel_fall = sel_clk_q && !sel_clk;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_q <= 7'h00;
         sel_clk_q <= 1'b0;
      end
      else
      begin
         pre_q <= pre_d;
         sel_clk_q <= sel_clk_d;
      end
   end

   assign oscillator_divide_clocks = pre_q[SCG_PRE_W-1:SCG_PRE_TAP0];

   // ****************************
   // Mode sequencer
   // ****************************
   always_comb
   begin
      state_d = state_q;
      wdt_d = wdt_q;
      case (state_q)
         SCG_RUN:
         begin
            if (stop_go)
            begin
               state_d = SCG_STOP;
               wdt_d = SCG_WDT_PRESET;
            end
            else if (wait_go)
            begin
               state_d = SCG_WAIT;
            end
         end
         SCG_STOP:
         begin
            if (wake)
            begin
               state_d = SCG_STOP_EXIT;
            end
         end
         SCG_STOP_EXIT:
         begin
            if (sel_fall)
            begin
               if (fast_exit)
               begin
                  state_d = SCG_RUN;
               end
               else
               begin
                  wdt_d = wdt_q - 12'h001;
                  if (!wdt_d[SCG_WDT_W-1])
                  begin
                     state_d = SCG_RUN;
                  end
               end
            end
         end
         SCG_WAIT:
         begin
            if (wake)
            begin
               state_d = SCG_RUN;
            end
         end
         default:
         begin
            state_d = SCG_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= SCG_RUN;
         wdt_q <= 12'h000;
      end
      else
      begin
         state_q <= state_d;
         wdt_q <= wdt_d;
      end
   end

   assign irq_wake = wake;

   // ****************************
   // Clock gates and peripheral limits
   // ****************************
   always_comb
   begin
      gate_d = '1;
      periph_d = '{adc_run: 1'b1, wdt_run: 1'b1, timer_event_only: 1'b0, serial_ext_only: 1'b0};
      gate_d.pll_run = pll_en;
      case (state_d)
         SCG_STOP:
         begin
            gate_d = '0;
            periph_d = '{adc_run: 1'b0, wdt_run: 1'b0, timer_event_only: 1'b1, serial_ext_only: 1'b1};
         end
         SCG_STOP_EXIT:
         begin
            gate_d.biu_run = 1'b0;
            gate_d.cpu_run = 1'b0;
         end
         SCG_WAIT:
         begin
            gate_d.osc_run = !ext_clk;
            gate_d.biu_run = 1'b0;
            gate_d.cpu_run = 1'b0;
            gate_d.wdt_div_run = 1'b0;
            periph_d.wdt_run = 1'b0;
            if (ctrl_q[SCG_CTRL_WAIT_SYS_STOP])
            begin
               gate_d.sys_run = 1'b0;
               gate_d.periph_run = 1'b0;
               periph_d = '{adc_run: 1'b0, wdt_run: 1'b0, timer_event_only: 1'b1, serial_ext_only: 1'b1};
            end
         end
         default:
         begin
            gate_d.pll_run = pll_en;
         end
      endcase
   end

   // Gate enables come only from flops, so no runt pulse
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gate_q <= '1;
         periph_q <= '{adc_run: 1'b1, wdt_run: 1'b1, timer_event_only: 1'b0, serial_ext_only: 1'b0};
      end
      else
      begin
         gate_q <= gate_d;
         periph_q <= periph_d;
      end
   end

   assign clk_gate = gate_q;
   assign periph_ctl = periph_q;

   // ****************************
   // Bus fixation pin mux
   // ****************************
   generate
      for (genvar i = 0; i < SCG_PIN_W; i++)
      begin : g_pin
         if ((i >= SCG_PIN_DHI_LO && i <= SCG_PIN_DHI_HI) || i == SCG_PIN_HBW)
         begin : g_hi
            assign port_sel[i] = byte_bus || (ctrl_q[SCG_CTRL_FIX_EN] && state_q != SCG_RUN);
         end
         else
         begin : g_lo
            assign port_sel[i] = ctrl_q[SCG_CTRL_FIX_EN] && state_q != SCG_RUN;
         end
      end
   endgenerate

   always_comb
   begin
      pins_d.val = (port_sel & port_pins.val) | (~port_sel & bus_pins.val);
      pins_d.oe = (port_sel & port_pins.oe) | (~port_sel & bus_pins.oe);
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pins_q <= '0;
      end
      else
      begin
         pins_q <= pins_d;
      end
   end

   assign pin_out = pins_q;

   // ****************************
   // Checks
   // ****************************
   sequence s_stop_entry;
      state_q == SCG_RUN && stop_go;
   endsequence

   sequence s_wdt_exit;
      state_q == SCG_STOP_EXIT && !fast_exit;
   endsequence

   a_stop_gates_low: assert property (@(posedge mclk) disable iff (!rst_n)
      s_stop_entry |=> gate_q == '0 && periph_q.timer_event_only)
      else $error("stop entry did not gate all clocks");

   a_stop_wdt_preset: assert property (@(posedge mclk) disable iff (!rst_n)
      s_stop_entry |=> wdt_q == 12'hFFF && state_q == SCG_STOP)
      else $error("watchdog not preset on stop entry");

   a_stop_div_high: assert property (@(posedge mclk) disable iff (!rst_n)
      state_q == SCG_STOP && $past(state_q) == SCG_STOP |-> oscillator_divide_clocks == 4'hF)
      else $error("divide clocks not high in stop");

   a_wdt_msb_exit: assert property (@(posedge mclk) disable iff (!rst_n)
      s_wdt_exit ##1 state_q == SCG_RUN |-> !wdt_q[SCG_WDT_W-1] ##1 gate_q.cpu_run)
      else $error("watchdog exit with counter msb set");

   a_fast_exit_edge: assert property (@(posedge mclk) disable iff (!rst_n)
      state_q == SCG_STOP_EXIT && fast_exit && sel_fall |=> state_q == SCG_RUN)
      else $error("fast exit missed divide clock edge");

   a_wait_wake: assert property (@(posedge mclk) disable iff (!rst_n)
      state_q == SCG_WAIT && wake |=> ##1 gate_q.cpu_run && gate_q.biu_run)
      else $error("wait not left on accepted interrupt");

   a_wait_sys_run: assert property (@(posedge mclk) disable iff (!rst_n)
      state_q == SCG_WAIT && $stable(state_q) && $stable(ctrl_q) |->
      gate_q.sys_run == !ctrl_q[SCG_CTRL_WAIT_SYS_STOP] && !gate_q.cpu_run)
      else $error("wait clock gating wrong");

   a_stop_disabled: assert property (@(posedge mclk) disable iff (!rst_n)
      state_q == SCG_RUN && stop_mode && ctrl_q[SCG_CTRL_STOP_DIS] && !wait_mode |=> state_q == SCG_RUN)
      else $error("disabled stop was taken");

   a_done_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
      done_q[SCG_STAT_STOP_DONE] && !(reg_wr && reg_addr == SCG_OFF_STAT) |=> done_q[SCG_STAT_STOP_DONE])
      else $error("stop executed bit lost");

   a_fix_release: assert property (@(posedge mclk) disable iff (!rst_n)
      state_q == SCG_RUN && !byte_bus |-> port_sel == '0)
      else $error("port substitution outside standby");

   a_no_wake_low: assert property (@(posedge mclk) disable iff (!rst_n)
      state_q == SCG_WAIT && irq_req.level <= processor_priority_level |=> state_q == SCG_WAIT)
      else $error("low priority interrupt ended wait");

endmodule

`default_nettype wire

// File: inc/scg_pkg.sv
// Constants, types and register layout of the standby clock gating controller
package scg_pkg;

   // ****************************
   // Register map
   // ****************************
   localparam int SCG_ADDR_W = 4;
   localparam logic [SCG_ADDR_W-1:0] SCG_OFF_CTRL = 4'h0;
   localparam logic [SCG_ADDR_W-1:0] SCG_OFF_STAT = 4'h4;

   // Control fields
   localparam int SCG_CTRL_STOP_DIS = 0;
   localparam int SCG_CTRL_EXT_CLK = 1;
   localparam int SCG_CTRL_FIX_EN = 2;
   localparam int SCG_CTRL_WAIT_SYS_STOP = 3;
   localparam int SCG_CTRL_PLL_EN = 4;
   localparam int SCG_CTRL_SYS_PLL = 5;
   localparam int SCG_CTRL_WDT_SEL = 6;
   localparam int SCG_CTRL_W = 8;
   localparam logic [SCG_CTRL_W-1:0] SCG_CTRL_RESET = 8'h10;

   // Status fields
   localparam int SCG_STAT_STOP_DONE = 0;
   localparam int SCG_STAT_WAIT_DONE = 1;
   localparam int SCG_STAT_STATE = 4;
   localparam int SCG_STAT_WDT = 16;

   // ****************************
   // Timing and widths
   // ****************************
   localparam int SCG_WDT_W = 12;
   localparam logic [SCG_WDT_W-1:0] SCG_WDT_PRESET = 12'hFFF;
   localparam int SCG_PRE_W = 7;
   localparam logic [SCG_PRE_W-1:0] SCG_PRE_IDLE = 7'h7F;
   localparam int SCG_PRE_TAP0 = 3;
   localparam int SCG_PIN_W = 44;
   // Pin groups: upper data byte and high byte strobe with their ports
   localparam int SCG_PIN_DHI_LO = 32;
   localparam int SCG_PIN_DHI_HI = 39;
   localparam int SCG_PIN_HBW = 42;

   // ****************************
   // Types
   // ****************************
   typedef enum logic [1:0] {SCG_RUN, SCG_STOP, SCG_STOP_EXIT, SCG_WAIT} scg_state_e;

   typedef struct packed {
      logic osc_run;
      logic pll_run;
      logic xin_run;
      logic sys_run;
      logic biu_run;
      logic cpu_run;
      logic periph_run;
      logic wdt_div_run;
   } scg_gate_s;

   typedef struct packed {
      logic adc_run;
      logic wdt_run;
      logic timer_event_only;
      logic serial_ext_only;
   } scg_periph_s;

   typedef struct packed {
      logic pending;
      logic enabled;
      logic [2:0] level;
   } scg_irq_s;

   typedef struct packed {
      logic [SCG_PIN_W-1:0] val;
      logic [SCG_PIN_W-1:0] oe;
   } scg_pins_s;

endpackage

// File: tb/scg_cpu_model.sv
// CPU core and interrupt side model facing the standby controller
`timescale 1ns/10ps
`default_nettype none

module scg_cpu_model
   import scg_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire scg_gate_s clk_gate,
   output logic stop_mode,
   output logic wait_mode,
   output scg_irq_s irq_req,
   output logic [2:0] processor_priority_level
);
   initial
   begin
      stop_mode = 1'b0;
      wait_mode = 1'b0;
      irq_req = '0;
      processor_priority_level = 3'h3;
   end

   // One cycle instruction pulses
   task automatic do_stop;
      stop_mode <= 1'b1;
      @(posedge mclk);
      stop_mode <= 1'b0;
   endtask

   task automatic do_wait;
      wait_mode <= 1'b1;
      @(posedge mclk);
      wait_mode <= 1'b0;
   endtask

   // Request held until the CPU accepts it
   task automatic raise(input logic en, input logic [2:0] lvl);
      irq_req <= '{pending: 1'b1, enabled: en, level: lvl};
   endtask

   // Acceptance only with running CPU clock
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         irq_req.pending <= 1'b0;
      else if (clk_gate.cpu_run && irq_req.enabled && (irq_req.level > processor_priority_level))
         irq_req.pending <= 1'b0;
   end
endmodule

`default_nettype wire

// File: tb/standby_clock_gating_controller_tb_top.sv
// Self-checking testbench of the standby controller
`timescale 1ns/10ps
`default_nettype none

module standby_clock_gating_controller_tb_top
   import scg_pkg::*;
;
   logic mclk;
   logic rst_n;
   logic [SCG_ADDR_W-1:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic stop_mode;
   logic wait_mode;
   scg_irq_s irq_req;
   logic [2:0] processor_priority_level;
   logic byte_bus;
   scg_pins_s bus_pins;
   scg_pins_s port_pins;
   scg_pins_s pin_out;
   scg_gate_s clk_gate;
   scg_periph_s periph_ctl;
   logic [3:0] oscillator_divide_clocks;
   logic irq_wake;
   int failures;
   int checks_done;
   int n;
   logic [31:0] rd;
   logic [11:0] dec;
   logic [43:0] msk;
   logic [7:0] wctl [3] = '{8'h10, 8'h18, 8'h02};
   logic [7:0] wgate [3] = '{8'hF2, 8'hE0, 8'h32};
   logic [3:0] wper [3] = '{4'h8, 4'h3, 4'h8};

   scg_standby i_scg_standby (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stop_mode,
      .wait_mode, .irq_req, .processor_priority_level, .byte_bus, .bus_pins, .port_pins, .pin_out, .clk_gate,
      .periph_ctl, .oscillator_divide_clocks, .irq_wake);
   scg_cpu_model i_scg_cpu_model (.mclk, .rst_n, .clk_gate, .stop_mode, .wait_mode, .irq_req,
      .processor_priority_level);

   // ****************************
   // Bus tasks and checks
   // ****************************
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
   endtask

   task automatic chk(input logic [87:0] got, input logic [87:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      d = reg_rdata;
   endtask

   task automatic wait_cpu(input int lim, output int cnt);
      cnt = 0;
      while (clk_gate.cpu_run !== 1'b1 && cnt < lim)
      begin
         @(posedge mclk);
         cnt++;
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ****************************
   // Clock, watchdog and tests
   // ****************************
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   initial
   begin
      #300000;
      failures++;
      wrap_up();
   end

   initial
   begin
      rst_n = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      byte_bus = 1'b0;
      bus_pins = '{val: 44'hAAA_AAAA_AAAA, oe: 44'hFFF_FFFF_FFFF};
      port_pins = '{val: 44'h555_5555_5555, oe: 44'h0F0_F0F0_F0F0};
      msk = 44'h4FF_0000_0000;
      failures = 0;
      checks_done = 0;
      tick(8);
      rst_n <= 1'b1;
      tick(1);
      // Reset values and unmapped address
      reg_write(4'h8, 32'hFF);
      reg_read(SCG_OFF_CTRL, rd);
      chk(rd, 32'h10);
      reg_read(SCG_OFF_STAT, rd);
      chk(rd, 32'h0);
      reg_read(4'h8, rd);
      chk(rd, 32'h0);
      // Stop refused when disabled
      reg_write(SCG_OFF_CTRL, 32'h11);
      i_scg_cpu_model.do_stop();
      tick(1);
      chk(clk_gate, 8'hFF);
      reg_read(SCG_OFF_STAT, rd);
      chk(rd, 32'h0);
      // Stop with fixation, fast exit
      reg_write(SCG_OFF_CTRL, 32'h16);
      i_scg_cpu_model.do_stop();
      tick(1);
      chk(clk_gate, 8'h00);
      chk(periph_ctl, 4'h3);
      chk(oscillator_divide_clocks, 4'hF);
      tick(1);
      chk(pin_out, port_pins);
      reg_read(SCG_OFF_STAT, rd);
      chk(rd, 32'h0FFF_0011);
      i_scg_cpu_model.raise(1'b1, 3'h3);
      tick(2);
      chk({irq_wake, clk_gate}, 9'h000);
      i_scg_cpu_model.raise(1'b0, 3'h5);
      tick(2);
      chk({irq_wake, clk_gate}, 9'h000);
      i_scg_cpu_model.raise(1'b1, 3'h5);
      tick(1);
      chk(irq_wake, 1'b1);
      tick(1);
      chk(clk_gate, 8'hF3);
      wait_cpu(20, n);
      chk(clk_gate.cpu_run, 1'b1);
      tick(2);
      chk(pin_out, bus_pins);
      reg_write(SCG_OFF_STAT, 32'h0);
      reg_read(SCG_OFF_STAT, rd);
      chk(rd[5:0], 6'h00);
      // Exit count on the /32 clock, then reset mid-exit
      reg_write(SCG_OFF_CTRL, 32'h62);
      reg_read(SCG_OFF_CTRL, rd);
      chk(rd, 32'h42);
      reg_write(SCG_OFF_CTRL, 32'h72);
      i_scg_cpu_model.do_stop();
      tick(1);
      i_scg_cpu_model.raise(1'b1, 3'h5);
      tick(258);
      reg_read(SCG_OFF_STAT, rd);
      dec = 12'hFFF - rd[27:16];
      chk({clk_gate.cpu_run, dec >= 12'd6 && dec <= 12'd10, rd[5:4]}, 4'b0110);
      rst_n <= 1'b0;
      tick(1);
      chk({clk_gate.biu_run, clk_gate.cpu_run}, 2'b11);
      tick(7);
      rst_n <= 1'b1;
      tick(1);
      reg_read(SCG_OFF_CTRL, rd);
      chk(rd, 32'h10);
      // Watchdog-timed exit on the /16 clock
      i_scg_cpu_model.do_stop();
      tick(1);
      i_scg_cpu_model.raise(1'b1, 3'h5);
      tick(1);
      wait_cpu(40000, n);
      chk(n >= 32736 && n <= 32816, 1'b1);
      // Wait mode variants
      for (int i = 0; i < 3; i++)
      begin
         reg_write(SCG_OFF_CTRL, {24'h0, wctl[i]});
         i_scg_cpu_model.do_wait();
         tick(1);
         chk(clk_gate, wgate[i]);
         chk(periph_ctl, wper[i]);
         i_scg_cpu_model.raise(1'b1, 3'h3);
         tick(2);
         chk({irq_wake, clk_gate.cpu_run}, 2'b00);
         i_scg_cpu_model.raise(1'b1, 3'h5);
         tick(1);
         wait_cpu(2, n);
         chk(clk_gate.cpu_run, 1'b1);
      end
      reg_read(SCG_OFF_STAT, rd);
      chk(rd[5:0], 6'h03);
      // Byte bus: upper data and high strobe always ports
      reg_write(SCG_OFF_CTRL, 32'h0);
      byte_bus <= 1'b1;
      tick(3);
      chk(pin_out, {(bus_pins.val & ~msk) | (port_pins.val & msk), (bus_pins.oe & ~msk) | (port_pins.oe & msk)});
      wrap_up();
   end
endmodule

`default_nettype wire
